// *** design/pfsc_top.sv ***
// Pad function and state control with AHB-Lite register access
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module pfsc_top
  import pfsc_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic deep_sleep_state,
  input wire logic hibernate,
  input wire logic two_wire_debug,
  input wire logic flash_forced,
  input wire logic conv_ext_supply,
  input wire logic osc_strap,
  input wire logic [NUM_PADS-1:0][NUM_FUNCS-1:0] fn_out,
  input wire logic [NUM_PADS-1:0][NUM_FUNCS-1:0] fn_oe,
  output logic [NUM_PADS-1:0] fn_in,
  output logic [NUM_PADS-1:0][3:0] pad_sel,
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  output logic [NUM_PADS-1:0] pad_pull_dn,
  output logic slow_clk_external,
  output logic conv_pad_free
);

  typedef struct packed {
    pfsc_cfg_t [NUM_PADS-1:0] cfg;
    pfsc_drv_t [NUM_PADS-1:0] drv;
    logic [NUM_PADS-1:0] in_meta;
    logic [NUM_PADS-1:0] in_sync;
    logic strap_meta;
    logic strap_sync;
    logic [1:0] boot_cnt;
    logic booted;
    logic osc_mode;
    logic slow_ext;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
  } pfsc_state_t;

  pfsc_state_t s_q;
  pfsc_state_t s_d;
  pfsc_drv_t [NUM_PADS-1:0] drv_c;
  logic conv_ok;

  // Converter pad only joins the mux when its converter is not in use
  assign conv_ok = (FLASH_VARIANT && flash_forced) || conv_ext_supply; // RQ10

  // Per-pad drive decision; mode priority is hibernate, sleep, then active
  for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
    always_comb begin
      pfsc_lp_t lp;
      pfsc_dir_t dir;
      logic usable;
      lp = LP_HIZ;
      dir = pfsc_dir_t'(DIR_TABLE[2*s_q.cfg[p].mux +: 2]);
      usable = 1'b1;
      if (p == PAD_CONV) begin
        usable = conv_ok; // RQ10
      end
      if (p == PAD_SLOW_XTAL) begin
        usable = s_q.slow_ext; // RQ11
      end
      drv_c[p] = '{oe: 1'b0, out: 1'b0, pull: 1'b0};
      if (hibernate || deep_sleep_state) begin
        lp = hibernate ? s_q.cfg[p].hib : s_q.cfg[p].sleep; // RQ2 RQ3
        if (hibernate && p == PAD_DBG_OUT) begin
          lp = two_wire_debug ? LP_DRV_HI : LP_DRV_LO; // RQ4
        end
        if (hibernate && p == PAD_OSC_EN && s_q.osc_mode) begin
          lp = LP_PULL; // RQ7
        end
        if (!usable) begin
          lp = LP_HIZ;
        end
        case (lp)
          LP_PULL: drv_c[p].pull = 1'b1;
          LP_DRV_LO: drv_c[p].oe = 1'b1;
          LP_DRV_HI: drv_c[p] = '{oe: 1'b1, out: 1'b1, pull: 1'b0};
          default: drv_c[p].oe = 1'b0;
        endcase
      end else if (p == PAD_OSC_EN && s_q.osc_mode) begin
        drv_c[p] = '{oe: 1'b1, out: 1'b1, pull: 1'b0}; // RQ6
      end else if (usable && s_q.cfg[p].en) begin // RQ12
        case (dir)
          DIR_OUT: drv_c[p] = '{oe: 1'b1, out: fn_out[p][s_q.cfg[p].mux],
                                pull: 1'b0}; // RQ14
          DIR_IN: drv_c[p].oe = 1'b0;
          DIR_OD: drv_c[p].oe = ~fn_out[p][s_q.cfg[p].mux]; // RQ14
          default: drv_c[p] = '{oe: fn_oe[p][s_q.cfg[p].mux],
                                out: fn_out[p][s_q.cfg[p].mux], pull: 1'b0};
        endcase
      end
    end
    assign pad_out[p] = s_q.drv[p].out;
    assign pad_oe[p] = s_q.drv[p].oe;
    assign pad_pull_dn[p] = s_q.drv[p].pull;
    assign pad_sel[p] = s_q.cfg[p].mux;
  end

  // Next state: synchronisers, strap capture, bus writes, then read data
  always_comb begin
    logic [7:0] idx;
    logic [31:0] rd;
    s_d = s_q;
    rd = 32'h0000_0000;
    idx = 8'h00;
    s_d.in_meta = pad_in;
    s_d.in_sync = s_q.in_meta;
    s_d.strap_meta = osc_strap;
    s_d.strap_sync = s_q.strap_meta;
    s_d.drv = drv_c;
    // Straps are caught once the synchronisers hold settled values
    if (!s_q.booted) begin
      if (s_q.boot_cnt == BOOT_WAIT) begin
        s_d.booted = 1'b1;
        s_d.osc_mode = s_q.strap_sync; // RQ6
        s_d.slow_ext = s_q.in_sync[PAD_SLOW_XTAL]; // RQ11
      end else begin
        s_d.boot_cnt = s_q.boot_cnt + 2'h1;
      end
    end
    // Data phase of a write lands here
    if (s_q.wr_pend) begin
      idx = s_q.wr_addr[9:2];
      if (s_q.wr_addr < STATUS_OFS && idx < 8'(NUM_PADS)) begin
        s_d.cfg[idx[3:0]] = pfsc_cfg_t'(hwdata[EN_BIT:MUX_LSB]); // RQ1 RQ14
      end
    end
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr;
      // Read from the updated copy so a write followed by a read is seen
      idx = haddr[9:2];
      if (haddr == STATUS_OFS) begin
        rd = {29'h0, s_q.osc_mode, conv_ok, s_q.slow_ext};
      end else if (haddr < STATUS_OFS && idx < 8'(NUM_PADS)) begin
        rd = {23'h0, s_d.cfg[idx[3:0]]};
      end
      s_d.rdata = rd;
    end
  end

  // One register for all state; reset leaves every pad undriven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0; // RQ15
      for (int i = 0; i < NUM_PADS; i++) begin
        s_q.cfg[i].mux <= BOOT_MASK[i] ? MUX_BOOT : MUX_DEFAULT; // RQ13
        s_q.cfg[i].en <= BOOT_MASK[i]; // RQ12
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign fn_in = s_q.in_sync;
  assign slow_clk_external = s_q.slow_ext;
  assign conv_pad_free = conv_ok;

  // Assertions
  // Two low edges first: before the first reset edge the pads hold unknowns
  rst_hiz_a: assert property (@(posedge hclk) // RQ15
    !hresetn ##1 !hresetn |-> pad_oe == '0 && pad_pull_dn == '0)
    else $error("pad not high impedance in reset");
  // Reset must be gone at the first edge, as the drive registers lag a cycle
  hib_dbg_out_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    hresetn && hibernate ##1 hibernate |-> pad_oe[PAD_DBG_OUT]
      && pad_out[PAD_DBG_OUT] == $past(two_wire_debug))
    else $error("debug data-out pad wrong in hibernate");
  osc_high_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
    s_q.osc_mode && !hibernate && !deep_sleep_state |=> pad_oe[PAD_OSC_EN]
      && pad_out[PAD_OSC_EN])
    else $error("oscillator enable not driven high");
  osc_hib_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    s_q.osc_mode && hibernate |=> !pad_oe[PAD_OSC_EN]
      && pad_pull_dn[PAD_OSC_EN])
    else $error("oscillator enable not released in hibernate");
  conv_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    !conv_ok ##1 !$past(conv_ok) |-> !pad_oe[PAD_CONV])
    else $error("converter pad driven while unavailable");
  slow_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    s_q.booted && !s_q.slow_ext |=> !pad_oe[PAD_SLOW_XTAL])
    else $error("slow crystal pad driven while crystal in use");
  lp_hiz_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
    deep_sleep_state && !hibernate && s_q.cfg[PAD_DBG_IN].sleep == LP_HIZ
      |=> !pad_oe[PAD_DBG_IN] && !pad_pull_dn[PAD_DBG_IN])
    else $error("pad not high impedance in deep sleep");
  hib_drive_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
    hibernate && s_q.cfg[PAD_FL_CS].hib == LP_DRV_HI |=> pad_oe[PAD_FL_CS]
      && pad_out[PAD_FL_CS])
    else $error("programmed hibernate drive missing");
  gp_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
    !s_q.cfg[NUM_PADS-1].en |=> !pad_oe[NUM_PADS-1])
    else $error("disabled pad is driven");
  boot_mux_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
    !s_q.booted |-> s_q.cfg[PAD_FL_CLK].mux == MUX_BOOT
      && s_q.cfg[PAD_DBG_OUT].mux == MUX_BOOT && s_q.cfg[12].mux == MUX_DEFAULT)
    else $error("boot mux setting wrong");
  od_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    !hibernate && !deep_sleep_state && s_q.cfg[11].en
      && DIR_TABLE[2*s_q.cfg[11].mux +: 2] == DIR_OD |=> !pad_out[11])
    else $error("open-drain pad driven high");
  boot_cap_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    !s_q.booted ##1 s_q.booted |-> s_q.osc_mode == $past(s_q.strap_sync)
      && s_q.slow_ext == $past(s_q.in_sync[PAD_SLOW_XTAL]))
    else $error("power-up strap capture wrong");

endmodule

// *** design/pfsc_pkg.sv ***
// Constants, types and the pad map of the pad function and state control
// Summary of operation
// RQ1 - Each pad powers up on its default function; others need a mux write.
// RQ2 - Deep sleep: pads high impedance unless programmed as pull or drive.
// RQ3 - Hibernate: pads high impedance unless programmed as pull or drive.
// RQ4 - Hibernate: debug data-out high in two-wire mode, low in four-wire.
// RQ5 - Software should enable flash pad pulldowns before deep sleep.
// RQ6 - Oscillator-enable pad is an output driven high from power-up; code drives it high only once the strap sets osc_mode, not in deep sleep.
// RQ7 - Hibernate: oscillator-enable pad released, pulldown keeps oscillator off.
// RQ8 - Software uses a power-up sense pad only as an output.
// RQ9 - Software never routes other functions to the antenna-select pads.
// RQ10 - Converter pad usable when flash forced on flash variant, or supply external.
// RQ11 - Slow-crystal pad pullup sensed at power-up frees it for digital use.
// RQ12 - After reset general pads stay high impedance until software programs them.
// RQ13 - Boot puts debug and flash pads on mux one, all others high impedance.
// RQ14 - Per-pad mux field picks a function; direction follows that function.
// RQ15 - While chip reset is asserted every pad is high impedance.
package pfsc_pkg;

  localparam int NUM_PADS = 16;
  localparam int NUM_FUNCS = 16;

  // Pad roles inside the pad array
  localparam int PAD_DBG_IN = 0;
  localparam int PAD_DBG_OUT = 1;
  localparam int PAD_DBG_CLK = 2;
  localparam int PAD_DBG_MODE = 3;
  localparam int PAD_FL_CLK = 4;
  localparam int PAD_FL_DOUT = 5;
  localparam int PAD_FL_DIN = 6;
  localparam int PAD_FL_CS = 7;
  localparam int PAD_OSC_EN = 8;
  localparam int PAD_CONV = 9;
  localparam int PAD_SLOW_XTAL = 10;

  // Register map: one word per pad, then status
  localparam logic [11:0] PAD_CFG_BASE = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h100;

  // Field layout of a pad configuration word
  localparam int MUX_LSB = 0;
  localparam int SLEEP_LSB = 4;
  localparam int HIB_LSB = 6;
  localparam int EN_BIT = 8;

  localparam logic [3:0] MUX_DEFAULT = 4'h0;
  localparam logic [3:0] MUX_BOOT = 4'h1;
  localparam logic [1:0] BOOT_WAIT = 2'h3;

  // Low-power pad setting
  typedef enum logic [1:0] {
    LP_HIZ = 2'b00,
    LP_PULL = 2'b01,
    LP_DRV_LO = 2'b10,
    LP_DRV_HI = 2'b11
  } pfsc_lp_t;

  // Direction class of a mux encoding
  typedef enum logic [1:0] {
    DIR_BIDIR = 2'b00,
    DIR_IN = 2'b01,
    DIR_OUT = 2'b10,
    DIR_OD = 2'b11
  } pfsc_dir_t;

  // Direction per encoding, shared by all pads
  localparam logic [2*NUM_FUNCS-1:0] DIR_TABLE = {
    DIR_IN, DIR_OUT, DIR_IN, DIR_OUT, DIR_IN, DIR_OD, DIR_BIDIR, DIR_IN,
    DIR_BIDIR, DIR_OUT, DIR_OD, DIR_IN, DIR_OUT, DIR_OUT, DIR_BIDIR, DIR_BIDIR
  };

  typedef struct packed {
    logic en;
    pfsc_lp_t hib;
    pfsc_lp_t sleep;
    logic [3:0] mux;
  } pfsc_cfg_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pull;
  } pfsc_drv_t;

  // Pads that the boot sequence enables on mux one
  localparam logic [NUM_PADS-1:0] BOOT_MASK = 16'h00ff;

endpackage

// *** bench/pfsc_board.sv ***
// Board model: strap resistors and pad wiring seen by the pad inputs
`timescale 1ns/10ps
module pfsc_board
  import pfsc_pkg::*;
#(
  parameter bit OSC_STRAP = 1'b1
) (
  input wire logic hclk,
  input wire logic xtal_pullup,
  input wire logic [NUM_PADS-1:0] pad_out,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] pad_pull_dn,
  output logic [NUM_PADS-1:0] pad_in,
  output logic osc_strap
);
  assign osc_strap = OSC_STRAP; // Board strap level
  logic [NUM_PADS-1:0] lvl_q = '0;
  assign pad_in = lvl_q;
  // Floating pads other than the oscillator-enable and slow-crystal pads toggle so a stale level never passes for a drive
  always @(posedge hclk) begin
    for (int i = 0; i < NUM_PADS; i++) begin
      if (pad_oe[i]) begin
        lvl_q[i] <= pad_out[i];
      end else if (pad_pull_dn[i] || i == PAD_OSC_EN) begin
        lvl_q[i] <= 1'b0;
      end else if (i == PAD_SLOW_XTAL) begin
        // Pullup when fitted; the crystal bias holds it low otherwise
        lvl_q[i] <= xtal_pullup;
      end else begin
        lvl_q[i] <= ~lvl_q[i];
      end
    end
  end
endmodule

// *** bench/pfsc_top_tb.sv ***
// Self-checking bench for the pad function and state control
`timescale 1ns/10ps
module pfsc_top_tb
  import pfsc_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic dss = 1'b0, hib = 1'b0, twd = 1'b0, ff = 1'b0, ces = 1'b0;
  logic xpu = 1'b1; // Slow crystal pullup fitted on the board
  logic hreadyout, hresp, osc_strap, slow_ext, conv_free;
  logic [NUM_PADS-1:0][NUM_FUNCS-1:0] fn_out, fn_oe;
  logic [NUM_PADS-1:0][3:0] pad_sel;
  logic [NUM_PADS-1:0] fn_in, pad_in, pad_out, pad_oe, pad_pull_dn;
  logic [1:0] d;
  int err_count = 0, comparisons = 0, cyc = 0;

  always #5 hclk = ~hclk;
  pfsc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .deep_sleep_state(dss), .hibernate(hib),
    .two_wire_debug(twd), .flash_forced(ff), .conv_ext_supply(ces),
    .osc_strap(osc_strap), .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fn_in),
    .pad_sel(pad_sel), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_dn(pad_pull_dn), .slow_clk_external(slow_ext),
    .conv_pad_free(conv_free));
  pfsc_board u_board (.hclk(hclk), .xtal_pullup(xpu), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_dn(pad_pull_dn), .pad_in(pad_in),
    .osc_strap(osc_strap));

  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // A hung handshake is cut short here
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One AHB single transfer; read data is taken at the data-phase edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask
  task automatic pc(input int p, input logic oe, out, pull);
    chk({29'h0, pad_oe[p], pad_pull_dn[p], pad_out[p] & pad_oe[p]},
        {29'h0, oe, pull, out & oe});
  endtask
  // Reset, pads checked in mid-reset, then boot defaults
  task automatic rst;
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({16'h0, pad_oe | pad_pull_dn}, 32'h0);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    for (int p = 0; p < NUM_PADS; p++) begin
      xfer(1'b0, 12'(4 * p), 32'h0, rd);
      chk(rd, (p < 8) ? 32'h101 : 32'h0);
      chk({28'h0, pad_sel[p]}, (p < 8) ? 32'h1 : 32'h0);
    end
    pc(12, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic lp(input int sh);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 12'h02c, 32'h100 | (s << sh), rd);
      settle();
      pc(11, s[1], s[0], s == 1);
      pc(12, 1'b0, 1'b0, 1'b0);
    end
  endtask

  initial begin
    fn_oe = '1;
    for (int p = 0; p < NUM_PADS; p++) begin
      for (int e = 0; e < NUM_FUNCS; e++) begin
        fn_out[p][e] = e[0];
      end
    end
    rst();
    // Oscillator-enable pad is given an output function only
    xfer(1'b1, 12'h020, 32'h102, rd);
    settle();
    pc(PAD_OSC_EN, 1'b1, 1'b1, 1'b0);
    xfer(1'b1, STATUS_OFS, 32'h0, rd);
    xfer(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h5);
    chk({30'h0, slow_ext, conv_free}, 32'h2);
    // Converter pad asks to drive while its converter is still in use
    xfer(1'b1, 12'h024, 32'h102, rd);
    settle();
    pc(PAD_CONV, 1'b0, 1'b0, 1'b0);
    ff <= 1'b1;
    settle();
    xfer(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h7);
    pc(PAD_CONV, 1'b1, 1'b0, 1'b0);
    ff <= 1'b0;
    ces <= 1'b1;
    settle();
    xfer(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h7);
    chk({31'h0, conv_free}, 32'h1);
    xfer(1'b1, 12'h200, 32'hffffffff, rd);
    xfer(1'b0, 12'h200, 32'h0, rd);
    chk(rd, 32'h0);
    // Every encoding on one pad: direction follows the function
    for (int e = 0; e < NUM_FUNCS; e++) begin
      xfer(1'b1, 12'h02c, 32'h100 | e, rd);
      settle();
      d = DIR_TABLE[2*e +: 2];
      pc(11, d == DIR_OD ? ~e[0] : d != DIR_IN, d != DIR_OD && e[0],
         1'b0);
      chk({28'h0, pad_sel[11]}, e);
    end
    for (int p = 4; p < 7; p++) begin
      xfer(1'b1, 12'(4 * p), 32'h111, rd);
    end
    dss <= 1'b1;
    lp(SLEEP_LSB);
    pc(PAD_FL_DIN, 1'b0, 1'b0, 1'b1);
    dss <= 1'b0;
    hib <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      twd <= t[0];
      settle();
      pc(PAD_DBG_OUT, 1'b1, t[0], 1'b0);
      pc(PAD_OSC_EN, 1'b0, 1'b0, 1'b1);
      // The driven level comes back through the pad input synchroniser
      repeat (4) @(posedge hclk);
      chk({31'h0, fn_in[PAD_DBG_OUT]}, t);
    end
    lp(HIB_LSB);
    xfer(1'b1, 12'h01c, 32'h1c1, rd);
    settle();
    pc(PAD_FL_CS, 1'b1, 1'b1, 1'b0);
    // Second power-up with the slow crystal fitted instead of the pullup
    xpu <= 1'b0;
    rst();
    hib <= 1'b0;
    settle();
    xfer(1'b0, STATUS_OFS, 32'h0, rd);
    chk(rd, 32'h6);
    chk({31'h0, slow_ext}, 32'h0);
    xfer(1'b1, 12'h028, 32'h102, rd);
    settle();
    pc(PAD_SLOW_XTAL, 1'b0, 1'b0, 1'b0);
    chk({31'h0, hresp}, 32'h0);
    stop_test();
  end
endmodule
